// ### hw/vic_pkg.sv
// Package of constants and carrier types for the vectored interrupt controller.
package vic_pkg;
  // ==========================================================================
  // Source counts and register layout.
  localparam int NUM_PERIPH = 15;
  localparam int NUM_SOURCES = 18;
  localparam int REG_W = 8;
  localparam int PC_W = 16;
  // Bit positions in irq_status_ctrl_reg.
  localparam int ST_INTE = 0;
  localparam int ST_T0IE = 1;
  localparam int ST_TCKIE = 2;
  localparam int ST_PEIE = 3;
  localparam int ST_INTF = 4;
  localparam int ST_T0IF = 5;
  localparam int ST_TCKIF = 6;
  localparam int ST_PERIPH_IRQ_PENDING = 7;
  // ==========================================================================
  // Vector addresses.
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_EXT = 16'h0008;
  localparam logic [15:0] VEC_T0 = 16'h0010;
  localparam logic [15:0] VEC_TCK = 16'h0018;
  localparam logic [15:0] VEC_PERIPH = 16'h0020;
  // Reset values.
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [14:0] PERIPH_RST = 15'h0000;
  // ==========================================================================
  // Dedicated source events, one-cycle pulses from the peripherals.
  typedef struct packed {
    logic ext_edge;
    logic timer0_ovf;
    logic tck_edge;
  } vic_ded_s;
  // Request to the core sequencer.
  typedef struct packed {
    logic take;
    logic [15:0] vector;
  } vic_req_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SERVICE = 3'b010,
    ST_SLEEP = 3'b100
  } vic_state_e;
endpackage

// ### hw/vic_top.sv
// Vectored interrupt controller: flags, enables, global disable, vectoring and wake-up.
//
// Function
// - Eighteen sources: pin, port change, timers, serial, sync port, converter, captures.
// - Six registers: core status, irq status/control, two enable, two request.
// - No request to core while global disable bit is set.
// - Accepting an interrupt sets the global disable bit.
// - On accept, core pushes return address then loads the vector.
// - Four vectors: pin, timer0, clock-pin edge, shared peripheral.
// - All peripheral sources share one vector.
// - Vectoring to a dedicated vector clears that source's flag.
// - Shared peripheral vectoring leaves request flags unchanged.
// - Flags set on their condition regardless of enables or global disable.
// - External event latency grows one cycle during two-cycle instructions.
// - Return-from-interrupt pops address and clears global disable.
// - Interrupt wake-up shows as set flags in status or request registers.
// - Wake with global enable loads vector; with disable, execution resumes.
// - Vectors are 08h pin, 10h timer0, 18h clock-pin edge.
// - Pending bit is OR of request flags ANDed with enables.
// - Flag set as its enable clears, globally enabled, vectors to 0x00.
`timescale 1ns/1ns
module vic_top #(
  parameter int NUM_PERIPH = vic_pkg::NUM_PERIPH
) (
  input wire logic mclk, // Core instruction clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire vic_pkg::vic_ded_s ded_evt, // Dedicated source event pulses.
  input wire logic [NUM_PERIPH-1:0] periph_evt, // Peripheral event pulses.
  input wire logic instr_boundary, // Core may take a request at this cycle.
  input wire logic return_from_irq, // Return-from-interrupt executed.
  input wire logic sleeping, // Core is in sleep.
  input wire logic status_we, // Write to irq_status_ctrl_reg.
  input wire logic [7:0] status_wdata, // Data for irq_status_ctrl_reg.
  input wire logic gdis_we, // Write to global_irq_disable.
  input wire logic gdis_wdata, // Data for global_irq_disable.
  input wire logic pie_we, // Write to both enable registers.
  input wire logic [NUM_PERIPH-1:0] pie_wdata, // Data for enable registers.
  input wire logic pir_we, // Write to both request registers.
  input wire logic [NUM_PERIPH-1:0] pir_wdata, // Data for request registers.
  output logic global_irq_disable, // Global disable bit of core_status_reg.
  output logic [7:0] irq_status_ctrl_reg, // Status/control register image.
  output logic [NUM_PERIPH-1:0] periph_enable_reg, // Enable registers 1 and 2.
  output logic [NUM_PERIPH-1:0] periph_request_reg, // Request registers 1 and 2.
  output vic_pkg::vic_req_s core_req, // Vector request pulse to the core.
  output logic wake // Wake pulse to the core.
);
  logic [3:0] ctrl_en;
  logic int_f, t0_f, tck_f;
  logic pend_ext, pend_t0, pend_tck, pend_per, any_pend;
  logic en_drop;
  logic flag_pulse;
  logic take;
  logic [15:0] next_vec;
  vic_pkg::vic_state_e state;

  // ==========================================================================
  // Pending logic.
  assign pend_ext = int_f & ctrl_en[vic_pkg::ST_INTE];
  assign pend_t0 = t0_f & ctrl_en[vic_pkg::ST_T0IE];
  assign pend_tck = tck_f & ctrl_en[vic_pkg::ST_TCKIE];
  assign pend_per = |(periph_request_reg & periph_enable_reg);
  assign any_pend = pend_ext | pend_t0 | pend_tck | (pend_per & ctrl_en[vic_pkg::ST_PEIE]);
  // A flag rising while its own enable is written off.
  assign flag_pulse = status_we & ~global_irq_disable & (
    (ded_evt.ext_edge & ctrl_en[vic_pkg::ST_INTE] & ~status_wdata[vic_pkg::ST_INTE]) |
    (ded_evt.timer0_ovf & ctrl_en[vic_pkg::ST_T0IE] & ~status_wdata[vic_pkg::ST_T0IE]) |
    (ded_evt.tck_edge & ctrl_en[vic_pkg::ST_TCKIE] & ~status_wdata[vic_pkg::ST_TCKIE]) |
    ((|(periph_evt & periph_enable_reg)) & ctrl_en[vic_pkg::ST_PEIE]
      & ~status_wdata[vic_pkg::ST_PEIE]));
  assign en_drop = flag_pulse;
  // Requests are taken only at an instruction boundary, so a two-cycle
  // instruction delays the response by one cycle.
  assign take = ~global_irq_disable & instr_boundary & (any_pend | en_drop);

  always_comb begin
    if (en_drop) begin
      next_vec = vic_pkg::VEC_RESET;
    end else if (pend_ext) begin
      next_vec = vic_pkg::VEC_EXT;
    end else if (pend_t0) begin
      next_vec = vic_pkg::VEC_T0;
    end else if (pend_tck) begin
      next_vec = vic_pkg::VEC_TCK;
    end else begin
      next_vec = vic_pkg::VEC_PERIPH;
    end
  end

  // ==========================================================================
  // Enable bits of the status/control register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_en <= vic_pkg::STATUS_RST[3:0];
    end else if (status_we) begin
      ctrl_en <= status_wdata[3:0];
    end
  end

  // Dedicated flags: set wins over software clear and over vector clear.
  always_ff @(posedge mclk) begin
    if (rst) begin
      int_f <= 1'b0;
      t0_f <= 1'b0;
      tck_f <= 1'b0;
    end else begin
      int_f <= ded_evt.ext_edge | (int_f & ~(status_we & ~status_wdata[vic_pkg::ST_INTF])
        & ~(take & next_vec == vic_pkg::VEC_EXT));
      t0_f <= ded_evt.timer0_ovf | (t0_f & ~(status_we & ~status_wdata[vic_pkg::ST_T0IF])
        & ~(take & next_vec == vic_pkg::VEC_T0));
      tck_f <= ded_evt.tck_edge | (tck_f & ~(status_we & ~status_wdata[vic_pkg::ST_TCKIF])
        & ~(take & next_vec == vic_pkg::VEC_TCK));
    end
  end

  // Peripheral flags: only software clears them, never the vectoring.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_pir
      always_ff @(posedge mclk) begin
        if (rst) begin
          periph_request_reg[gi] <= 1'b0;
        end else if (periph_evt[gi]) begin
          periph_request_reg[gi] <= 1'b1;
        end else if (pir_we) begin
          periph_request_reg[gi] <= pir_wdata[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (rst) begin
      periph_enable_reg <= vic_pkg::PERIPH_RST[NUM_PERIPH-1:0];
    end else if (pie_we) begin
      periph_enable_reg <= pie_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_status_ctrl_reg <= vic_pkg::STATUS_RST;
    end else begin
      irq_status_ctrl_reg <= {pend_per, tck_f, t0_f, int_f, ctrl_en};
    end
  end

  // ==========================================================================
  // Global disable: accept sets it, return clears it.
  always_ff @(posedge mclk) begin
    if (rst) begin
      global_irq_disable <= 1'b1;
    end else if (take) begin
      global_irq_disable <= 1'b1;
    end else if (return_from_irq) begin
      global_irq_disable <= 1'b0;
    end else if (gdis_we) begin
      global_irq_disable <= gdis_wdata;
    end
  end

  // Request to core: the core pushes the return address, then loads the vector.
  always_ff @(posedge mclk) begin
    if (rst) begin
      core_req <= '0;
    end else begin
      core_req.take <= take;
      core_req.vector <= next_vec;
    end
  end

  // Sleep tracking and wake-up.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= vic_pkg::ST_IDLE;
      wake <= 1'b0;
    end else begin
      wake <= 1'b0;
      case (state)
        vic_pkg::ST_IDLE: begin
          if (take) begin
            state <= vic_pkg::ST_SERVICE;
          end else if (sleeping) begin
            state <= vic_pkg::ST_SLEEP;
          end
        end
        vic_pkg::ST_SERVICE: begin
          if (return_from_irq) begin
            state <= vic_pkg::ST_IDLE;
          end
        end
        vic_pkg::ST_SLEEP: begin
          if (any_pend) begin
            wake <= 1'b1;
            state <= global_irq_disable ? vic_pkg::ST_IDLE : vic_pkg::ST_SERVICE;
          end
        end
        default: state <= vic_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Checks.
  a_no_req_disabled: assert property (@(posedge mclk) disable iff (rst)
    global_irq_disable |=> !core_req.take) else $error("request while disabled");
  a_take_sets_dis: assert property (@(posedge mclk) disable iff (rst)
    take |=> global_irq_disable) else $error("disable not set on accept");
  a_ret_clears: assert property (@(posedge mclk) disable iff (rst)
    (return_from_irq && !take) |=> !global_irq_disable) else $error("return left disable");
  a_ext_vec_clr: assert property (@(posedge mclk) disable iff (rst)
    (take && next_vec == vic_pkg::VEC_EXT && !ded_evt.ext_edge) |=> !int_f)
    else $error("ext flag kept");
  a_per_kept: assert property (@(posedge mclk) disable iff (rst)
    (take && next_vec == vic_pkg::VEC_PERIPH && !pir_we && !(|periph_evt)) |=>
    (periph_request_reg == $past(periph_request_reg))) else $error("periph flags changed");
  a_flag_sets: assert property (@(posedge mclk) disable iff (rst)
    ded_evt.timer0_ovf |=> t0_f) else $error("timer0 flag missed");
  a_prio_ext: assert property (@(posedge mclk) disable iff (rst)
    (take && pend_ext && !en_drop) |=> core_req.vector == vic_pkg::VEC_EXT)
    else $error("priority wrong");
  a_pend_or: assert property (@(posedge mclk) disable iff (rst)
    ##1 irq_status_ctrl_reg[vic_pkg::ST_PERIPH_IRQ_PENDING] ==
    $past(|(periph_request_reg & periph_enable_reg))) else $error("pending bit wrong");
  a_drop_vec: assert property (@(posedge mclk) disable iff (rst)
    (take && en_drop) |=> core_req.vector == vic_pkg::VEC_RESET)
    else $error("dropped enable vector wrong");
  c_ext: cover property (@(posedge mclk) core_req.take && core_req.vector == vic_pkg::VEC_EXT);
  c_per: cover property (@(posedge mclk) core_req.take && core_req.vector == vic_pkg::VEC_PERIPH);
  c_wake: cover property (@(posedge mclk) wake);
  c_drop: cover property (@(posedge mclk) core_req.take && core_req.vector == vic_pkg::VEC_RESET);
endmodule

// ### testbench/vic_core_model.sv
// Behavioural model of the processor core that faces the interrupt controller.
`timescale 1ns/1ns
module vic_core_model (
  input wire logic mclk, // Core clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire vic_pkg::vic_req_s core_req, // Vector request from the controller.
  input wire logic do_ret, // Bench command to execute a return.
  output logic return_from_irq, // Return-from-interrupt executed.
  output logic [15:0] program_counter, // Program counter.
  output logic [3:0] depth // Hardware stack depth.
);
  logic [15:0] stack [0:15];
  always_ff @(posedge mclk) begin
    if (rst) begin
      program_counter <= 16'h0100;
      depth <= 4'h0;
      return_from_irq <= 1'b0;
    end else begin
      return_from_irq <= do_ret;
      if (core_req.take) begin
        stack[depth] <= program_counter;
        depth <= depth + 4'h1;
        program_counter <= core_req.vector;
      end else if (do_ret) begin
        program_counter <= stack[depth - 4'h1];
        depth <= depth - 4'h1;
      end else begin
        program_counter <= program_counter + 16'h0001;
      end
    end
  end
endmodule

// ### testbench/vic_top_tb.sv
// Self-checking bench for the vectored interrupt controller.
`timescale 1ns/1ns
module vic_top_tb;
  logic mclk, rst, instr_boundary, sleeping, do_ret, ret_irq, got;
  logic status_we, gdis_we, gdis_wdata, pie_we, pir_we, gdis, wake;
  logic [14:0] periph_evt, pie_wdata, pir_wdata, pie_q, pir_q;
  logic [7:0] status_wdata, st_q;
  logic [15:0] pc;
  logic [3:0] depth;
  logic [15:0] vecs [0:2];
  vic_pkg::vic_ded_s ded_evt;
  vic_pkg::vic_req_s core_req;
  int fail_count, n_tests, cycles, ntake, nwake;
  vic_top uut (.mclk(mclk), .rst(rst), .ded_evt(ded_evt), .periph_evt(periph_evt),
    .instr_boundary(instr_boundary), .return_from_irq(ret_irq), .sleeping(sleeping),
    .status_we(status_we), .status_wdata(status_wdata), .gdis_we(gdis_we),
    .gdis_wdata(gdis_wdata), .pie_we(pie_we), .pie_wdata(pie_wdata), .pir_we(pir_we),
    .pir_wdata(pir_wdata), .global_irq_disable(gdis), .irq_status_ctrl_reg(st_q),
    .periph_enable_reg(pie_q), .periph_request_reg(pir_q), .core_req(core_req), .wake(wake));
  vic_core_model core (.mclk(mclk), .rst(rst), .core_req(core_req), .do_ret(do_ret),
    .return_from_irq(ret_irq), .program_counter(pc), .depth(depth));
  // ==========================================================================
  // Tasks.
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input int k, input logic [14:0] d);
    status_wdata = d[7:0];
    gdis_wdata = d[0];
    pie_wdata = d;
    pir_wdata = d;
    {status_we, gdis_we, pie_we, pir_we} = 4'h8 >> k;
    cyc(1);
    {status_we, gdis_we, pie_we, pir_we} = 4'h0;
    cyc(1);
  endtask
  task automatic evt(input logic [2:0] d, input logic [14:0] p);
    ded_evt = d;
    periph_evt = p;
    cyc(1);
    ded_evt = 3'h0;
    periph_evt = 15'h0;
    cyc(1);
  endtask
  task automatic ret();
    do_ret = 1'b1;
    cyc(1);
    do_ret = 1'b0;
    cyc(1);
  endtask
  task automatic wait_take(input logic [15:0] exp);
    got = 1'b0;
    for (int k = 0; k < 20 && !got; k++) begin
      if (core_req.take === 1'b1) got = 1'b1;
      else cyc(1);
    end
    check({got, core_req.vector, gdis}, {1'b1, exp, 1'b1});
  endtask
  // ==========================================================================
  // Clock, cycle ceiling and event counters.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (core_req.take === 1'b1) ntake++;
    if (wake === 1'b1) nwake++;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  // ==========================================================================
  // Test sequence.
  initial begin
    vecs = '{vic_pkg::VEC_EXT, vic_pkg::VEC_T0, vic_pkg::VEC_TCK};
    {rst, instr_boundary} = 2'b11;
    {sleeping, do_ret, status_we, gdis_we, gdis_wdata, pie_we, pir_we} = 7'h0;
    {periph_evt, pie_wdata, pir_wdata, status_wdata, ded_evt} = '0;
    cyc(20);
    rst = 1'b0;
    cyc(1);
    check({gdis, st_q, pie_q, pir_q, core_req.take, wake}, {1'b1, 40'h0});
    evt(3'h7, 15'h7fff);
    cyc(2);
    check({st_q, pir_q}, {8'h70, 15'h7fff});
    wr(0, 15'h000f);
    wr(2, 15'h0020);
    cyc(2);
    check(st_q, 8'h8f);
    check(pie_q, 15'h0020);
    check(ntake, 0);
    evt(3'h7, 15'h0000);
    instr_boundary = 1'b0;
    wr(1, 15'h0000);
    cyc(5);
    check(ntake, 0);
    instr_boundary = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wait_take(vecs[i]);
      cyc(1);
      check({pc, depth}, {vecs[i], 4'h1});
      cyc(1);
      check(st_q[4 + i], 1'b0);
      ret();
      check({gdis, depth}, 5'h0);
    end
    wait_take(vic_pkg::VEC_PERIPH);
    cyc(2);
    check(pir_q, 15'h7fff);
    ret();
    wait_take(vic_pkg::VEC_PERIPH);
    wr(3, 15'h0000);
    ret();
    cyc(5);
    check({ntake, gdis, st_q[7]}, {32'h5, 2'b00});
    wr(1, 15'h0001);
    sleeping = 1'b1;
    evt(3'h4, 15'h0000);
    cyc(4);
    check({nwake != 0, st_q[4]}, 2'b11);
    check(ntake, 5);
    sleeping = 1'b0;
    wr(1, 15'h0000);
    wait_take(vic_pkg::VEC_EXT);
    cyc(2);
    ret();
    // Pin event in the very cycle that its enable is written off.
    status_wdata = 8'h0e;
    status_we = 1'b1;
    ded_evt = 3'h4;
    cyc(1);
    status_we = 1'b0;
    ded_evt = 3'h0;
    wait_take(vic_pkg::VEC_RESET);
    cyc(2);
    stop_test();
  end
endmodule
